// ===== src/lmr_pkg.sv
// package for the literal/move/return execution block
// assumes one 10 MHz core clock and a synchronous active-high reset
//
// How it works
// - bank literal loads bank select, flags untouched
// - page literal loads program counter high latch
// - accumulator literal load, one word, one cycle
// - accumulator stored to banked file register
// - indirect store through pointer chosen by bit
// - update field: pre inc, pre dec, post inc/dec
// - relative form: pointer plus signed offset, unchanged
// - indirect port has no storage, uses pointer
// - pointers are sixteen bits and wrap around
// - pointer stepping never touches status flags
// - software reset resets device, clears reset flag
// - interrupt return pops stack, loads pc, two cycles
// - interrupt return sets global interrupt enable bit
package lmr_pkg;

  typedef enum logic [3:0] {
    OP_NO_OP      = 4'h0,
    OP_LOAD_BANK  = 4'h1,
    OP_LOAD_PAGE  = 4'h2,
    OP_LOAD_ACC   = 4'h3,
    OP_STORE_FILE = 4'h4,
    OP_STORE_IND  = 4'h5,
    OP_SW_RESET   = 4'h6,
    OP_RET_INT    = 4'h7
  } lmr_op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RET = 2'b01,
    ST_RST = 2'b10
  } lmr_state_t;

  // decoded instruction word as handed over by the fetch stage
  typedef struct packed {
    lmr_op_t    op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic       ptr_sel;
    logic [1:0] pointer_update_field;
    logic       relative;
    logic [5:0] offset;
  } lmr_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } lmr_mem_wr_t;

  // register port offsets
  localparam logic [3:0] REG_ACC    = 4'h0;
  localparam logic [3:0] REG_BANK   = 4'h1;
  localparam logic [3:0] REG_PAGE   = 4'h2;
  localparam logic [3:0] REG_PTR0_L = 4'h3;
  localparam logic [3:0] REG_PTR0_H = 4'h4;
  localparam logic [3:0] REG_PTR1_L = 4'h5;
  localparam logic [3:0] REG_PTR1_H = 4'h6;
  localparam logic [3:0] REG_INTCTL = 4'h7;
  localparam logic [3:0] REG_PWRCTL = 4'h8;
  localparam logic [3:0] REG_STATE  = 4'h9;

  // field positions
  localparam int INT_EN_BIT     = 7;
  localparam int SWRST_FLAG_BIT = 2;

  // values after reset
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [5:0]  BANK_RST   = 6'h00;
  localparam logic [6:0]  PAGE_RST   = 7'h00;
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [7:0]  INTCTL_RST = 8'h00;
  localparam logic [7:0]  PWRCTL_RST = 8'h04;

  // file addresses that name the two indirect access ports
  localparam logic [6:0] PORT0_ADDR = 7'h00;
  localparam logic [6:0] PORT1_ADDR = 7'h01;

endpackage

// ===== src/lmr_exec.sv
// execution unit for literal loads, accumulator stores, no-op,
// software reset and return from interrupt
// assumes decoded instructions arrive synchronous to clk and that
// device_reset_req is not looped back onto rst
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module lmr_exec (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // instruction stream
  input  wire logic                 instr_valid,
  input  wire lmr_pkg::lmr_instr_t  instr,
  output logic                      instr_ready,
  // hardware stack and program counter
  input  wire logic [14:0]          stack_top_entry,
  output logic                      stack_pop,
  output logic                      pc_load,
  output logic [14:0]               pc_value,
  // data memory write port
  output logic                      mem_we,
  output lmr_pkg::lmr_mem_wr_t      mem_wr,
  // device reset request
  output logic                      device_reset_req,
  // architectural state
  output logic [5:0]                bank_select,
  output logic [6:0]                program_counter_high_latch,
  output logic [7:0]                accumulator,
  output logic                      global_interrupt_enable,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // wraps modulo 2^16 by construction
  function automatic logic [15:0] step_ptr(
    input logic [15:0] p,
    input logic [1:0]  m
  );
    step_ptr = m[0] ? 16'(p - 16'h0001) : 16'(p + 16'h0001);
  endfunction

  function automatic logic [15:0] ind_addr(
    input logic [15:0]        p,
    input lmr_pkg::lmr_instr_t i
  );
    if (i.relative)
      ind_addr = 16'(p + {{10{i.offset[5]}}, i.offset});
    else if (!i.pointer_update_field[1])
      ind_addr = step_ptr(p, i.pointer_update_field);
    else
      ind_addr = p;
  endfunction

  function automatic logic [15:0] ptr_after(
    input logic [15:0]        p,
    input lmr_pkg::lmr_instr_t i
  );
    // relative form never writes back
    ptr_after = i.relative ? p : step_ptr(p, i.pointer_update_field);
  endfunction

  // one decoded operation, taken this cycle
  function automatic logic op_hit(
    input logic             taken,
    input lmr_pkg::lmr_op_t op,
    input lmr_pkg::lmr_op_t want
  );
    op_hit = taken && (op == want);
  endfunction

  // one register port write aimed at a given offset
  function automatic logic port_hit(
    input logic       strobe,
    input logic [3:0] addr,
    input logic [3:0] want
  );
    port_hit = strobe && (addr == want);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  lmr_pkg::lmr_state_t state_reg;
  lmr_pkg::lmr_state_t state_next;
  logic        ready_reg;
  logic        do_reset;
  logic        take;
  logic [15:0] cur_ptr;
  logic [7:0]  acc_reg;
  logic [5:0]  bank_reg;
  logic [6:0]  page_reg;
  logic [15:0] ptr_reg [2];
  logic [7:0]  intctl_reg;
  logic [7:0]  pwrctl_reg;
  logic        pop_reg;
  logic        pcld_reg;
  logic [14:0] pcval_reg;
  logic        we_reg;
  lmr_pkg::lmr_mem_wr_t wr_reg;
  logic        swrst_reg;
  logic [7:0]  rdata_reg;
  // decoded instructions
  logic        do_bank;
  logic        do_page;
  logic        do_acc;
  logic        do_file;
  logic        do_ind;
  logic        do_ret;
  logic        do_swrst;
  // decoded port writes
  logic        wr_acc;
  logic        wr_bank;
  logic        wr_page;
  logic        wr_intctl;
  logic        wr_pwrctl;

  // the cycle after a software reset acts as a device reset
  assign do_reset = rst | swrst_reg;
  // a request while ready is low is simply not taken
  assign take     = instr_valid & ready_reg;
  assign cur_ptr  = ptr_reg[instr.ptr_sel];

  // do_ind, do_ret and do_swrst are each looked at in more than one process
  assign do_bank   = op_hit(take, instr.op, lmr_pkg::OP_LOAD_BANK);
  assign do_page   = op_hit(take, instr.op, lmr_pkg::OP_LOAD_PAGE);
  assign do_acc    = op_hit(take, instr.op, lmr_pkg::OP_LOAD_ACC);
  assign do_file   = op_hit(take, instr.op, lmr_pkg::OP_STORE_FILE);
  assign do_ind    = op_hit(take, instr.op, lmr_pkg::OP_STORE_IND);
  assign do_ret    = op_hit(take, instr.op, lmr_pkg::OP_RET_INT);
  assign do_swrst  = op_hit(take, instr.op, lmr_pkg::OP_SW_RESET);
  assign wr_acc    = port_hit(reg_wr, reg_addr, lmr_pkg::REG_ACC);
  assign wr_bank   = port_hit(reg_wr, reg_addr, lmr_pkg::REG_BANK);
  assign wr_page   = port_hit(reg_wr, reg_addr, lmr_pkg::REG_PAGE);
  assign wr_intctl = port_hit(reg_wr, reg_addr, lmr_pkg::REG_INTCTL);
  assign wr_pwrctl = port_hit(reg_wr, reg_addr, lmr_pkg::REG_PWRCTL);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lmr_pkg::ST_RUN: begin
        if (do_ret)
          state_next = lmr_pkg::ST_RET;
        else if (do_swrst)
          state_next = lmr_pkg::ST_RST;
      end
      lmr_pkg::ST_RET: state_next = lmr_pkg::ST_RUN;
      lmr_pkg::ST_RST: state_next = lmr_pkg::ST_RUN;
      default:         state_next = lmr_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (do_reset) begin
      state_reg <= lmr_pkg::ST_RUN;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      // one-cycle ops keep ready high back to back
      ready_reg <= (state_next == lmr_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // literal loads and accumulator; instruction beats a port write

  always_ff @(posedge clk) begin
    if (do_reset) begin
      acc_reg <= lmr_pkg::ACC_RST;
    end else if (do_acc) begin
      acc_reg <= instr.literal;
    end else if (wr_acc) begin
      acc_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (do_reset) begin
      bank_reg <= lmr_pkg::BANK_RST;
    end else if (do_bank) begin
      bank_reg <= instr.literal[5:0];
    end else if (wr_bank) begin
      bank_reg <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (do_reset) begin
      page_reg <= lmr_pkg::PAGE_RST;
    end else if (do_page) begin
      page_reg <= instr.literal[6:0];
    end else if (wr_page) begin
      page_reg <= reg_wdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // indirect pointers; no status flag path exists here at all

  always_ff @(posedge clk) begin
    if (do_reset) begin
      ptr_reg[0] <= lmr_pkg::PTR_RST;
      ptr_reg[1] <= lmr_pkg::PTR_RST;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          lmr_pkg::REG_PTR0_L: ptr_reg[0][7:0]  <= reg_wdata;
          lmr_pkg::REG_PTR0_H: ptr_reg[0][15:8] <= reg_wdata;
          lmr_pkg::REG_PTR1_L: ptr_reg[1][7:0]  <= reg_wdata;
          lmr_pkg::REG_PTR1_H: ptr_reg[1][15:8] <= reg_wdata;
          default: ;
        endcase
      end
      // the stepping op wins over a port write to its own pointer
      if (do_ind) begin
        ptr_reg[instr.ptr_sel] <= ptr_after(cur_ptr, instr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data memory writes

  always_ff @(posedge clk) begin
    if (do_reset) begin
      we_reg <= 1'b0;
      wr_reg <= '0;
    end else begin
      we_reg <= 1'b0;
      if (do_file) begin
        we_reg      <= 1'b1;
        wr_reg.data <= acc_reg;
        if (instr.file_addr == lmr_pkg::PORT0_ADDR)
          wr_reg.addr <= ptr_reg[0];
        else if (instr.file_addr == lmr_pkg::PORT1_ADDR)
          wr_reg.addr <= ptr_reg[1];
        else
          wr_reg.addr <= {3'b000, bank_reg, instr.file_addr};
      end else if (do_ind) begin
        we_reg      <= 1'b1;
        wr_reg.data <= acc_reg;
        wr_reg.addr <= ind_addr(cur_ptr, instr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // return from interrupt

  always_ff @(posedge clk) begin
    if (do_reset) begin
      pop_reg   <= 1'b0;
      pcld_reg  <= 1'b0;
      pcval_reg <= '0;
    end else begin
      pop_reg  <= 1'b0;
      pcld_reg <= (state_reg == lmr_pkg::ST_RET);
      if (do_ret) begin
        // latch the return address before the pop moves the top
        pcval_reg <= stack_top_entry;
        pop_reg   <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_reset) begin
      intctl_reg <= lmr_pkg::INTCTL_RST;
    end else if (state_reg == lmr_pkg::ST_RET) begin
      intctl_reg[lmr_pkg::INT_EN_BIT] <= 1'b1;
    end else if (wr_intctl) begin
      intctl_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software reset; the flag survives its own reset cycle

  always_ff @(posedge clk) begin
    if (rst) begin
      swrst_reg <= 1'b0;
    end else begin
      swrst_reg <= do_swrst;
    end
  end

  // a hardware reset, or a port write to REG_PWRCTL with bit 2 set, raises the flag again
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrctl_reg <= lmr_pkg::PWRCTL_RST;
    end else if (do_swrst) begin
      pwrctl_reg[lmr_pkg::SWRST_FLAG_BIT] <= 1'b0;
    end else if (wr_pwrctl) begin
      pwrctl_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        lmr_pkg::REG_ACC:    rdata_reg <= acc_reg;
        lmr_pkg::REG_BANK:   rdata_reg <= {2'b00, bank_reg};
        lmr_pkg::REG_PAGE:   rdata_reg <= {1'b0, page_reg};
        lmr_pkg::REG_PTR0_L: rdata_reg <= ptr_reg[0][7:0];
        lmr_pkg::REG_PTR0_H: rdata_reg <= ptr_reg[0][15:8];
        lmr_pkg::REG_PTR1_L: rdata_reg <= ptr_reg[1][7:0];
        lmr_pkg::REG_PTR1_H: rdata_reg <= ptr_reg[1][15:8];
        lmr_pkg::REG_INTCTL: rdata_reg <= intctl_reg;
        lmr_pkg::REG_PWRCTL: rdata_reg <= pwrctl_reg;
        lmr_pkg::REG_STATE:  rdata_reg <= {6'h00, state_reg};
        default:             rdata_reg <= 8'h00;
      endcase
    end else begin
      // zero between reads so a stale value is never taken
      rdata_reg <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all flop driven

  assign instr_ready                = ready_reg;
  assign stack_pop                  = pop_reg;
  assign pc_load                    = pcld_reg;
  assign pc_value                   = pcval_reg;
  assign mem_we                     = we_reg;
  assign mem_wr                     = wr_reg;
  assign device_reset_req           = swrst_reg;
  assign bank_select                = bank_reg;
  assign program_counter_high_latch = page_reg;
  assign accumulator                = acc_reg;
  assign global_interrupt_enable    = intctl_reg[lmr_pkg::INT_EN_BIT];
  assign reg_rdata                  = rdata_reg;

endmodule // lmr_exec

// ===== verification/lmr_exec_properties.sv
// concurrent checks on the execution block, seen from its ports only
// assumes one clock domain and rst synchronous active high
module lmr_exec_properties (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // instruction stream and stack
  input wire logic                 instr_valid,
  input wire lmr_pkg::lmr_instr_t  instr,
  input wire logic                 instr_ready,
  input wire logic [14:0]          stack_top_entry,
  input wire logic                 stack_pop,
  input wire logic                 pc_load,
  input wire logic [14:0]          pc_value,
  // memory, reset request, state and the port write strobe
  input wire logic                 mem_we,
  input wire lmr_pkg::lmr_mem_wr_t mem_wr,
  input wire logic                 device_reset_req,
  input wire logic [5:0]           bank_select,
  input wire logic [6:0]           program_counter_high_latch,
  input wire logic [7:0]           accumulator,
  input wire logic                 global_interrupt_enable,
  input wire logic                 reg_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = instr_valid && instr_ready;
  ////////////////////////////////////////////////////////////////////
  property p_bank;
    take && instr.op == lmr_pkg::OP_LOAD_BANK
      |=> bank_select == $past(instr.literal[5:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not loaded");
  property p_page;
    take && instr.op == lmr_pkg::OP_LOAD_PAGE
      |=> program_counter_high_latch == $past(instr.literal[6:0]);
  endproperty
  a_page: assert property (p_page) else $error("page not loaded");
  property p_acc;
    take && instr.op == lmr_pkg::OP_LOAD_ACC
      |=> accumulator == $past(instr.literal);
  endproperty
  a_acc: assert property (p_acc) else $error("acc not loaded");
  property p_file;
    take && instr.op == lmr_pkg::OP_STORE_FILE && instr.file_addr > 7'h01
      |=> mem_we && mem_wr.data == $past(accumulator)
        && mem_wr.addr == {3'b000, $past(bank_select), $past(instr.file_addr)};
  endproperty
  a_file: assert property (p_file) else $error("file store wrong");
  property p_ind;
    take && instr.op == lmr_pkg::OP_STORE_IND
      |=> mem_we && mem_wr.data == $past(accumulator);
  endproperty
  a_ind: assert property (p_ind) else $error("ind store");
  property p_ret;
    take && instr.op == lmr_pkg::OP_RET_INT
      |=> stack_pop && !instr_ready && pc_value == $past(stack_top_entry)
        ##1 pc_load && global_interrupt_enable;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_swrst;
    take && instr.op == lmr_pkg::OP_SW_RESET
      |=> device_reset_req ##1 accumulator == 8'h00 && bank_select == 6'h00;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset wrong");
  property p_no_op;
    take && instr.op == lmr_pkg::OP_NO_OP && !reg_wr
      |=> !mem_we && !stack_pop && $stable(accumulator)
        && $stable(bank_select);
  endproperty
  a_no_op: assert property (p_no_op) else $error("no-op changed");
endmodule // lmr_exec_properties

bind lmr_exec lmr_exec_properties i_lmr_exec_properties (
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .stack_top_entry(stack_top_entry),
  .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
  .mem_we(mem_we), .mem_wr(mem_wr), .device_reset_req(device_reset_req),
  .bank_select(bank_select), .accumulator(accumulator),
  .program_counter_high_latch(program_counter_high_latch),
  .global_interrupt_enable(global_interrupt_enable), .reg_wr(reg_wr));

// ===== verification/lmr_exec_tb.sv
// self-checking bench: instruction stream and register port tasks
// assumes the package and the execution block are compiled first
module lmr_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk = 1'b0;
  logic                 rst, instr_valid, instr_ready, stack_pop, pc_load;
  logic                 mem_we, device_reset_req, int_en, reg_wr, reg_rd;
  logic                 we_seen, pop_seen, rq_seen;
  lmr_pkg::lmr_instr_t  instr;
  lmr_pkg::lmr_mem_wr_t mem_wr, wr_seen;
  logic [14:0]          stack_top_entry, pc_value;
  logic [5:0]           bank;
  logic [6:0]           page;
  logic [7:0]           acc, reg_wdata, reg_rdata;
  logic [3:0]           reg_addr;
  int                   err_count = 0, n_tests = 0, cyc = 0;
  localparam logic [15:0] EA [4] = '{16'h1001, 16'h0FFF, 16'h1000, 16'h1000};
  localparam logic [15:0] EP [4] = '{16'h1001, 16'h0FFF, 16'h1001, 16'h0FFF};

  lmr_exec i_lmr_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready),
    .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_value(pc_value), .mem_we(mem_we),
    .mem_wr(mem_wr), .device_reset_req(device_reset_req),
    .bank_select(bank), .program_counter_high_latch(page),
    .accumulator(acc), .global_interrupt_enable(int_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short at cycle 3000, well beyond the about 130 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic setp(input logic s, input logic [15:0] v);
    wr(s ? lmr_pkg::REG_PTR1_L : lmr_pkg::REG_PTR0_L, v[7:0]);
    wr(s ? lmr_pkg::REG_PTR1_H : lmr_pkg::REG_PTR0_H, v[15:8]);
  endtask
  task automatic ptrc(input logic s, input logic [15:0] v);
    rd(s ? lmr_pkg::REG_PTR1_L : lmr_pkg::REG_PTR0_L, v[7:0]);
    rd(s ? lmr_pkg::REG_PTR1_H : lmr_pkg::REG_PTR0_H, v[15:8]);
  endtask
  // pulses of the one cycle after the take are captured mid-cycle
  task automatic ex(input lmr_pkg::lmr_op_t op, input logic [7:0] lit = 8'h00,
      input logic [6:0] fa = 7'h00, input logic sel = 1'b0,
      input logic [1:0] upd = 2'b00, input logic rel = 1'b0,
      input logic [5:0] off = 6'h00);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= {op, lit, fa, sel, upd, rel, off};
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    we_seen = mem_we;
    wr_seen = mem_wr;
    pop_seen = stack_pop;
    rq_seen = device_reset_req;
  endtask
  task automatic ind(input logic s, input logic [1:0] upd, input logic rel,
      input logic [5:0] off, input logic [15:0] p, ea, ep);
    setp(s, p);
    ex(lmr_pkg::OP_STORE_IND, 8'h00, 7'h00, s, upd, rel, off);
    chk({15'h0000, we_seen}, 16'h0001);
    chk(wr_seen.addr, ea);
    chk({8'h00, wr_seen.data}, 16'h005A);
    ptrc(s, ep);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    stack_top_entry = 15'h1234;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(lmr_pkg::REG_PWRCTL, 8'h04);
    rd(lmr_pkg::REG_INTCTL, 8'h00);
    wr(4'h9, 8'h02);
    rd(4'h9, 8'h00);
    rd(4'hF, 8'h00);
    ex(lmr_pkg::OP_LOAD_BANK, 8'hFF);
    rd(lmr_pkg::REG_BANK, 8'h3F);
    ex(lmr_pkg::OP_LOAD_PAGE, 8'hFF);
    chk({9'h000, page}, 16'h007F);
    ex(lmr_pkg::OP_LOAD_ACC, 8'h5A);
    chk({8'h00, acc}, 16'h005A);
    ex(lmr_pkg::OP_STORE_FILE, 8'h00, 7'h45);
    chk(wr_seen.addr, 16'h1FC5);
    ex(lmr_pkg::OP_NO_OP);
    chk({7'h00, we_seen, acc}, 16'h005A);
    for (int m = 0; m < 4; m++)
      ind(1'b1, m[1:0], 1'b0, 6'h00, 16'h1000, EA[m], EP[m]);
    ind(1'b0, 2'b00, 1'b0, 6'h00, 16'hFFFF, 16'h0000, 16'h0000);
    ind(1'b0, 2'b01, 1'b0, 6'h00, 16'h0000, 16'hFFFF, 16'hFFFF);
    ind(1'b1, 2'b00, 1'b1, 6'h20, 16'h1000, 16'h0FE0, 16'h1000);
    ind(1'b1, 2'b11, 1'b1, 6'h1F, 16'h1000, 16'h101F, 16'h1000);
    ex(lmr_pkg::OP_STORE_FILE, 8'h00, 7'h01);
    chk(wr_seen.addr, 16'h1000);
    ptrc(1'b1, 16'h1000);
    wr(lmr_pkg::REG_INTCTL, 8'h41);
    ex(lmr_pkg::OP_RET_INT);
    chk({pop_seen, pc_value}, 16'h9234);
    @(negedge clk);
    chk({14'h0000, pc_load, int_en}, 16'h0003);
    rd(lmr_pkg::REG_INTCTL, 8'hC1);
    ex(lmr_pkg::OP_SW_RESET);
    chk({15'h0000, rq_seen}, 16'h0001);
    rd(lmr_pkg::REG_ACC, 8'h00);
    rd(lmr_pkg::REG_PWRCTL, 8'h00);
    ptrc(1'b1, 16'h0000);
    chk({15'h0000, int_en}, 16'h0000);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd(lmr_pkg::REG_PWRCTL, 8'h04);
    give_verdict;
  end
endmodule // lmr_exec_tb
